/* File: ats_pkg.sv */
// shared constants for the task file drive/head, status and command block
package ats_pkg;

  // register port offsets (address lines 2..0)
  localparam logic [2:0] OFS_DRIVE_HEAD   = 3'h6;
  localparam logic [2:0] OFS_STATUS       = 3'h7;
  localparam logic [2:0] OFS_COMMAND      = 3'h7;
  localparam logic [2:0] OFS_STATUS_ALT   = 3'h6;

  // drive/head select fields
  localparam int         DH_ONE_HI_BIT    = 7;
  localparam int         DH_LINEAR_BIT    = 6;
  localparam int         DH_ONE_LO_BIT    = 5;
  localparam int         DH_SELECT_BIT    = 4;
  localparam int         DH_HEAD_MSB      = 3;
  localparam logic [7:0] DH_RESET         = 8'hA0;

  // status fields
  localparam int         ST_BUSY_BIT      = 7;
  localparam int         ST_READY_BIT     = 6;
  localparam int         ST_FAULT_BIT     = 5;
  localparam int         ST_SEEK_BIT      = 4;
  localparam int         ST_XFER_BIT      = 3;
  localparam int         ST_CORRECTED_DATA_FLAG_BIT      = 2;
  localparam int         ST_INDEX_BIT     = 1;
  localparam int         ST_ERR_BIT       = 0;

  // used-parameter vector: one bit per task file input
  localparam int         USE_W            = 7;
  localparam logic [6:0] USE_FEATURE      = 7'h01;
  localparam logic [6:0] USE_COUNT        = 7'h02;
  localparam logic [6:0] USE_SECTOR       = 7'h04;
  localparam logic [6:0] USE_CYLINDER     = 7'h08;
  localparam logic [6:0] USE_DRIVE        = 7'h10;
  localparam logic [6:0] USE_HEAD         = 7'h20;
  localparam logic [6:0] USE_LINEAR       = 7'h40;
  localparam int         USE_FEATURE_BIT  = 0;
  localparam int         USE_COUNT_BIT    = 1;

  // configuration index values that make a configured I/O card
  localparam logic [1:0] IDX_IO_PRIMARY   = 2'h1;
  localparam logic [1:0] IDX_IO_SECONDARY = 2'h3;

  // zero count means the maximum transfer
  localparam logic [8:0] COUNT_MAX        = 9'h100;

  typedef enum logic [1:0] {ATS_IDLE, ATS_RUN, ATS_DATA} ats_state_t;

endpackage

/* File: ats_cmd_decode.sv */
// command code decoder: validity, media class and used-parameter vector
`timescale 1ns/1ps
module ats_cmd_decode
(
  input  wire logic [7:0] code_in,     // command byte
  output logic            valid_out,   // code is supported
  output logic            media_out,   // read, write or seek class
  output logic [6:0]      use_out      // task file inputs consumed
);

  localparam logic [6:0] U_DR   = ats_pkg::USE_DRIVE;
  localparam logic [6:0] U_SCDR = ats_pkg::USE_COUNT | ats_pkg::USE_DRIVE;
  localparam logic [6:0] U_LOC  = ats_pkg::USE_SECTOR | ats_pkg::USE_CYLINDER
                                | ats_pkg::USE_DRIVE | ats_pkg::USE_HEAD
                                | ats_pkg::USE_LINEAR;

  always_comb
  begin
    valid_out = 1'b1;
    media_out = 1'b0;
    use_out   = U_DR;
    casez (code_in)
      8'hE5, 8'h98, 8'h90, 8'hEC, 8'hE1, 8'h95, 8'hE4, 8'h1?, 8'h03,
      8'hE6, 8'h99, 8'hE2, 8'h96, 8'hE0, 8'h94, 8'hE8:
        use_out = U_DR;
      8'hEF:
        use_out = U_DR | ats_pkg::USE_FEATURE;
      8'hE3, 8'h97, 8'hC6:
        use_out = U_SCDR;
      8'h91:
        use_out = U_SCDR | ats_pkg::USE_HEAD;
      8'hF5:
        use_out = U_DR | ats_pkg::USE_HEAD;
      8'h50:
        use_out = U_LOC & ~ats_pkg::USE_SECTOR | ats_pkg::USE_COUNT;
      8'hC0, 8'h87:
        use_out = U_LOC | ats_pkg::USE_COUNT;
      8'h22, 8'h23, 8'h32, 8'h33, 8'h7?:
      begin
        use_out   = U_LOC;
        media_out = 1'b1;
      end
      8'h20, 8'h21, 8'h40, 8'h41, 8'hC4, 8'hC5, 8'h30, 8'h31, 8'h3C:
      begin
        use_out   = U_LOC | ats_pkg::USE_COUNT;
        media_out = 1'b1;
      end
      8'hCD, 8'h38:
      begin
        use_out   = U_LOC | ats_pkg::USE_COUNT;
        media_out = 1'b1;
      end
      default:
      begin
        valid_out = 1'b0;
        use_out   = 7'h00;
      end
    endcase
  end

endmodule

/* File: ats_taskfile.sv */
// drive/head select, status and command registers of the card task file
// Operation
// - drive/head bits 7 and 5 always read as one
// - drive/head bit 6 picks geometric (0) or linear (1) addressing
// - linear address: sector, cylinder low, cylinder high, head field
// - drive/head bit 4 selects card; only matching card takes commands
// - drive/head bits 3..0 are head number, bit 3 most significant
// - status read in I/O index 1..3 with level interrupts negates request
// - busy bit high during internal work; other bits then invalid
// - read, write, seek need ready and seek complete; refused otherwise
// - status bit 5 shows write fault
// - status bit 4 shows seek complete
// - transfer request rises for data phase, cleared by other command
// - status bit 2 shows corrected data error
// - status bit 1 always reads zero
// - status bit 0 flags failed previous command, cleared by next
// - shadow status has same contents, reading leaves request alone
// - command write starts decoded operation; feature byte only for EFH
// - CDH uses count and location parameters, never the feature byte
// - 38H uses count and location parameters, never the feature byte
// - transfer count of zero means 256 sectors
// - command that cannot run sets the aborted flag
`timescale 1ns/1ps
module ats_taskfile
#(
  parameter int LBA_W = 28                       // linear address width
)
(
  input  wire logic             sys_clk_in,      // system clock
  input  wire logic             rst_b_in,        // async reset, active low
  input  wire logic             iord_b_in,       // host read strobe pin
  input  wire logic             iowr_b_in,       // host write strobe pin
  input  wire logic             alt_block_in,    // high selects control block
  input  wire logic [2:0]       addr_in,         // register address pins
  input  wire logic [7:0]       data_in,         // host data pins, input
  output logic      [7:0]       data_out,        // host data pins, output
  output logic                  data_oe_b_out,   // low while driving data
  input  wire logic             card_number_in,  // own card number
  input  wire logic [1:0]       config_index_in, // configuration index
  input  wire logic             level_irq_in,    // level interrupt mode
  input  wire logic             irq_enable_in,   // request enable
  input  wire logic [7:0]       feature_in,      // feature byte
  input  wire logic [7:0]       count_in,        // sector count
  input  wire logic [7:0]       sector_in,       // sector number
  input  wire logic [7:0]       cyl_low_in,      // cylinder low
  input  wire logic [7:0]       cyl_high_in,     // cylinder high
  input  wire logic             ready_in,        // drive ready
  input  wire logic             seek_done_in,    // seek complete
  input  wire logic             write_fault_in,  // write fault present
  input  wire logic             corrected_in,    // corrected error pulse
  input  wire logic             data_phase_in,   // back end wants data moved
  input  wire logic             data_done_in,    // data phase over
  input  wire logic             cmd_done_in,     // command finished pulse
  input  wire logic             cmd_error_in,    // finished with error
  output logic                  cmd_start_out,   // command launch pulse
  output logic      [7:0]       cmd_code_out,    // launched command
  output logic      [6:0]       cmd_use_out,     // used-parameter vector
  output logic      [7:0]       feature_out,     // feature byte or zero
  output logic      [8:0]       xfer_count_out,  // sectors, 1..256
  output logic      [LBA_W-1:0] lba_addr_out,    // linear block address
  output logic                  linear_addressing_flag_out, // linear mode
  output logic                  card_select_bit_out,        // selected card
  output logic      [3:0]       head_field_out,  // head number
  output logic                  aborted_flag_out,// abort pulse
  output logic                  interrupt_request_n_out     // request, low
);

  initial
  begin
    if (LBA_W != 28)
      $error("ats_taskfile: linear address must be 28 bits");
  end

  localparam int SYN_W = 14;

  // pin synchroniser; third stage only for strobe edges
  logic [SYN_W-1:0] syn1;
  logic [SYN_W-1:0] syn2;
  logic [1:0]       syn3;

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      syn1 <= {2'h3, 12'h000};
      syn2 <= {2'h3, 12'h000};
      syn3 <= 2'h3;
    end
    else
    begin
      syn1 <= {iord_b_in, iowr_b_in, alt_block_in, addr_in, data_in};
      syn2 <= syn1;
      syn3 <= syn2[SYN_W-1 -: 2];
    end
  end

  logic       rd_b;
  logic       wr_b;
  logic       alt_s;
  logic [2:0] addr_s;
  logic [7:0] wdata_s;
  logic       rd_start;
  logic       wr_start;

  assign rd_b     = syn2[13];
  assign wr_b     = syn2[12];
  assign alt_s    = syn2[11];
  assign addr_s   = syn2[10:8];
  assign wdata_s  = syn2[7:0];
  assign rd_start = !rd_b && syn3[1];
  assign wr_start = !wr_b && syn3[0];

  logic       dec_valid;
  logic       dec_media;
  logic [6:0] dec_use;

  ats_cmd_decode u_dec
  (
    .code_in   (wdata_s),
    .valid_out (dec_valid),
    .media_out (dec_media),
    .use_out   (dec_use)
  );

  ats_pkg::ats_state_t state;
  ats_pkg::ats_state_t next_state;
  logic [7:0]          dh;
  logic [7:0]          next_dh;
  logic                err;
  logic                next_err;
  logic                corrected_data_flag;
  logic                next_corrected_data_flag;
  logic                irq_pend;
  logic                next_irq_pend;
  logic [7:0]          next_data;
  logic                next_oe_b;
  logic                next_start;
  logic [7:0]          next_code;
  logic [6:0]          next_use;
  logic [7:0]          next_feature;
  logic [8:0]          next_count;
  logic [LBA_W-1:0]    next_lba;
  logic                next_abort;
  logic [7:0]          status;
  logic                io_level;
  logic                cmd_hit;
  logic                cmd_refuse;

  always_comb
  begin
    status = 8'h00;
    status[ats_pkg::ST_BUSY_BIT]  = (state == ats_pkg::ATS_RUN);
    status[ats_pkg::ST_READY_BIT] = ready_in;
    status[ats_pkg::ST_FAULT_BIT] = write_fault_in;
    status[ats_pkg::ST_SEEK_BIT]  = seek_done_in;
    status[ats_pkg::ST_XFER_BIT]  = (state == ats_pkg::ATS_DATA);
    status[ats_pkg::ST_CORRECTED_DATA_FLAG_BIT]  = corrected_data_flag;
    status[ats_pkg::ST_INDEX_BIT] = 1'b0;
    status[ats_pkg::ST_ERR_BIT]   = err;
  end

  // configured I/O card with level interrupts
  assign io_level = level_irq_in
                    && (config_index_in >= ats_pkg::IDX_IO_PRIMARY)
                    && (config_index_in <= ats_pkg::IDX_IO_SECONDARY);

  // command write aimed at this card; busy card ignores it
  assign cmd_hit = wr_start && !alt_s && (addr_s == ats_pkg::OFS_COMMAND)
                   && (dh[ats_pkg::DH_SELECT_BIT] == card_number_in)
                   && (state != ats_pkg::ATS_RUN);
  assign cmd_refuse = !dec_valid || write_fault_in || !ready_in
                      || (dec_media && !seek_done_in);

  always_comb
  begin
    next_state    = state;
    next_dh       = dh;
    next_err      = err;
    next_corrected_data_flag     = corrected_data_flag;
    next_irq_pend = irq_pend;
    next_data     = data_out;
    next_oe_b     = data_oe_b_out;
    next_start    = 1'b0;
    next_code     = cmd_code_out;
    next_use      = cmd_use_out;
    next_feature  = feature_out;
    next_count    = xfer_count_out;
    next_lba      = lba_addr_out;
    next_abort    = 1'b0;

    // reads: data latched on the strobe edge, held until strobe ends
    if (rd_b)
      next_oe_b = 1'b1;
    else if (rd_start)
    begin
      if (!alt_s && addr_s == ats_pkg::OFS_DRIVE_HEAD)
      begin
        next_data = dh;
        next_data[ats_pkg::DH_ONE_HI_BIT] = 1'b1;
        next_data[ats_pkg::DH_ONE_LO_BIT] = 1'b1;
        next_oe_b = 1'b0;
      end
      else if (!alt_s && addr_s == ats_pkg::OFS_STATUS)
      begin
        next_data = status;
        next_oe_b = 1'b0;
        if (io_level)
          next_irq_pend = 1'b0;
      end
      else if (alt_s && addr_s == ats_pkg::OFS_STATUS_ALT)
      begin
        next_data = status;
        next_oe_b = 1'b0;
      end
    end

    // drive/head write; constant bits stored as one
    if (wr_start && !alt_s && addr_s == ats_pkg::OFS_DRIVE_HEAD)
    begin
      next_dh = wdata_s;
      next_dh[ats_pkg::DH_ONE_HI_BIT] = 1'b1;
      next_dh[ats_pkg::DH_ONE_LO_BIT] = 1'b1;
    end

    if (cmd_hit)
    begin
      next_corrected_data_flag     = 1'b0;
      next_irq_pend = 1'b0;
      if (cmd_refuse)
      begin
        next_state    = ats_pkg::ATS_IDLE;
        next_err      = 1'b1;
        next_abort    = 1'b1;
        next_irq_pend = 1'b1;
      end
      else
      begin
        next_state   = ats_pkg::ATS_RUN;
        next_err     = 1'b0;
        next_start   = 1'b1;
        next_code    = wdata_s;
        next_use     = dec_use;
        next_feature = dec_use[ats_pkg::USE_FEATURE_BIT]
                       ? feature_in : 8'h00;
        next_count   = (count_in == 8'h00) ? ats_pkg::COUNT_MAX
                       : {1'b0, count_in};
        next_lba     = {dh[ats_pkg::DH_HEAD_MSB:0], cyl_high_in,
                        cyl_low_in, sector_in};
      end
    end
    else
    begin
      case (state)
        ats_pkg::ATS_IDLE:
          next_state = ats_pkg::ATS_IDLE;
        ats_pkg::ATS_RUN:
        begin
          if (cmd_done_in)
          begin
            next_state    = ats_pkg::ATS_IDLE;
            next_err      = cmd_error_in;
            next_irq_pend = 1'b1;
          end
          else if (data_phase_in)
          begin
            next_state    = ats_pkg::ATS_DATA;
            next_irq_pend = 1'b1;
          end
        end
        ats_pkg::ATS_DATA:
        begin
          if (cmd_done_in)
          begin
            next_state    = ats_pkg::ATS_IDLE;
            next_err      = cmd_error_in;
            next_irq_pend = 1'b1;
          end
          else if (data_done_in)
            next_state = ats_pkg::ATS_RUN;
        end
        default:
          next_state = ats_pkg::ATS_IDLE;
      endcase
    end

    // corrected event wins over the clear at command start
    if (corrected_in)
      next_corrected_data_flag = 1'b1;
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state                      <= ats_pkg::ATS_IDLE;
      dh                         <= ats_pkg::DH_RESET;
      err                        <= 1'b0;
      corrected_data_flag                       <= 1'b0;
      irq_pend                   <= 1'b0;
      data_out                   <= 8'h00;
      data_oe_b_out              <= 1'b1;
      cmd_start_out              <= 1'b0;
      cmd_code_out               <= 8'h00;
      cmd_use_out                <= 7'h00;
      feature_out                <= 8'h00;
      xfer_count_out             <= ats_pkg::COUNT_MAX;
      lba_addr_out               <= '0;
      aborted_flag_out           <= 1'b0;
      linear_addressing_flag_out <= 1'b0;
      card_select_bit_out        <= 1'b0;
      head_field_out             <= 4'h0;
      interrupt_request_n_out    <= 1'b1;
    end
    else
    begin
      state                      <= next_state;
      dh                         <= next_dh;
      err                        <= next_err;
      corrected_data_flag                       <= next_corrected_data_flag;
      irq_pend                   <= next_irq_pend;
      data_out                   <= next_data;
      data_oe_b_out              <= next_oe_b;
      cmd_start_out              <= next_start;
      cmd_code_out               <= next_code;
      cmd_use_out                <= next_use;
      feature_out                <= next_feature;
      xfer_count_out             <= next_count;
      lba_addr_out               <= next_lba;
      aborted_flag_out           <= next_abort;
      linear_addressing_flag_out <= next_dh[ats_pkg::DH_LINEAR_BIT];
      card_select_bit_out        <= next_dh[ats_pkg::DH_SELECT_BIT];
      head_field_out             <= next_dh[ats_pkg::DH_HEAD_MSB:0];
      interrupt_request_n_out    <= !(next_irq_pend && irq_enable_in);
    end
  end

endmodule

/* File: ats_taskfile_sva.sv */
// concurrent checks on the task file block ports
`timescale 1ns/1ps
module ats_taskfile_sva
#(
  parameter int LBA_W = 28                                    // address width
)
(
  input wire logic             sys_clk_in,                    // clock
  input wire logic             rst_b_in,                      // reset
  input wire logic             iord_b_in,                     // read strobe
  input wire logic             alt_block_in,                  // control block
  input wire logic [2:0]       addr_in,                       // address
  input wire logic [7:0]       data_out,                      // read data
  input wire logic             data_oe_b_out,                 // drive enable
  input wire logic             card_number_in,                // own number
  input wire logic [1:0]       config_index_in,               // index
  input wire logic             level_irq_in,                  // level mode
  input wire logic [7:0]       count_in,                      // count
  input wire logic [7:0]       sector_in,                     // sector
  input wire logic [7:0]       cyl_low_in,                    // cylinder low
  input wire logic [7:0]       cyl_high_in,                   // cylinder high
  input wire logic             ready_in,                      // ready
  input wire logic             write_fault_in,                // fault
  input wire logic             cmd_start_out,                 // launch
  input wire logic [7:0]       cmd_code_out,                  // code
  input wire logic [6:0]       cmd_use_out,                   // used inputs
  input wire logic [8:0]       xfer_count_out,                // sectors
  input wire logic [LBA_W-1:0] lba_addr_out,                  // block address
  input wire logic             card_select_bit_out,           // select
  input wire logic [3:0]       head_field_out,                // head
  input wire logic             aborted_flag_out,              // abort
  input wire logic             interrupt_request_n_out        // request
);
  logic rd_on;
  logic rd_dh;
  logic rd_st;
  logic rd_alt;
  // read data trusted only while strobe still low and bus driven
  assign rd_on  = !iord_b_in && !data_oe_b_out;
  assign rd_dh  = rd_on && !alt_block_in && addr_in == ats_pkg::OFS_DRIVE_HEAD;
  assign rd_st  = rd_on && !alt_block_in && addr_in == ats_pkg::OFS_STATUS;
  assign rd_alt = rd_on && alt_block_in && addr_in == ats_pkg::OFS_STATUS_ALT;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  property p_dh_ones;
    rd_dh |-> data_out[7] && data_out[5];
  endproperty
  a_dh_ones: assert property (p_dh_ones) else $error("fixed select bits not one");
  property p_idx_zero;
    rd_st || rd_alt |-> !data_out[ats_pkg::ST_INDEX_BIT];
  endproperty
  a_idx_zero: assert property (p_idx_zero) else $error("index bit set");
  property p_levels;
    (rd_st || rd_alt) && !data_out[7] |-> data_out[6] == ready_in && data_out[5] == write_fault_in;
  endproperty
  a_levels: assert property (p_levels) else $error("status levels wrong");
  property p_alt_keep;
    rd_alt |-> !$rose(interrupt_request_n_out);
  endproperty
  a_alt_keep: assert property (p_alt_keep) else $error("shadow read moved request");
  property p_negate;
    rd_st && config_index_in != 2'h0 && level_irq_in |-> ##[0:2] interrupt_request_n_out;
  endproperty
  a_negate: assert property (p_negate) else $error("request not negated");
  property p_count;
    cmd_start_out |-> xfer_count_out == (count_in == 8'h00 ? 9'h100 : {1'b0, count_in});
  endproperty
  a_count: assert property (p_count) else $error("sector count wrong");
  property p_lba;
    cmd_start_out |-> lba_addr_out == {head_field_out, cyl_high_in, cyl_low_in, sector_in};
  endproperty
  a_lba: assert property (p_lba) else $error("block address wrong");
  property p_feat;
    cmd_start_out |-> cmd_use_out[ats_pkg::USE_FEATURE_BIT] == (cmd_code_out == 8'hEF);
  endproperty
  a_feat: assert property (p_feat) else $error("feature use wrong");
  property p_gate;
    cmd_start_out |-> ready_in && !write_fault_in && card_select_bit_out == card_number_in;
  endproperty
  a_gate: assert property (p_gate) else $error("launch not allowed");
  property p_pulse;
    cmd_start_out |-> !aborted_flag_out ##1 !cmd_start_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("launch pulse wrong");
  c_start: cover property (cmd_start_out);
  c_abort: cover property (aborted_flag_out);
  c_negate: cover property (rd_st && !interrupt_request_n_out);
endmodule

bind ats_taskfile ats_taskfile_sva #(.LBA_W(LBA_W)) u_ats_taskfile_sva
(
  .sys_clk_in, .rst_b_in, .iord_b_in, .alt_block_in, .addr_in, .data_out, .data_oe_b_out,
  .card_number_in, .config_index_in, .level_irq_in, .count_in, .sector_in, .cyl_low_in,
  .cyl_high_in, .ready_in, .write_fault_in, .cmd_start_out, .cmd_code_out, .cmd_use_out,
  .xfer_count_out, .lba_addr_out, .card_select_bit_out, .head_field_out, .aborted_flag_out,
  .interrupt_request_n_out
);

/* File: ats_host_model.sv */
// host side model driving the byte-wide register port
`timescale 1ns/1ps
module ats_host_model
(
  input  wire logic       sys_clk_in,    // clock
  input  wire logic [7:0] rd_data_in,    // card data
  input  wire logic       rd_oe_b_in,    // card drive enable
  output logic            iord_b_out,    // read strobe
  output logic            iowr_b_out,    // write strobe
  output logic            alt_block_out, // control block
  output logic      [2:0] addr_out,      // address
  output logic      [7:0] wr_data_out    // write data
);
  initial
  begin
    iord_b_out = 1'b1;
    iowr_b_out = 1'b1;
    alt_block_out = 1'b0;
    addr_out = 3'h0;
    wr_data_out = 8'hFF;
  end
  // strobe low 5 clocks, high 4: both above the 3-clock minimum
  task automatic acc(input logic wr, input logic alt, input logic [2:0] a,
                     input logic [7:0] d, output logic [8:0] q);
    @(posedge sys_clk_in);
    alt_block_out <= alt;
    addr_out <= a;
    wr_data_out <= d;
    @(posedge sys_clk_in);
    iowr_b_out <= !wr;
    iord_b_out <= wr;
    repeat (5) @(posedge sys_clk_in);
    q = {rd_oe_b_in, rd_data_in};
    iord_b_out <= 1'b1;
    iowr_b_out <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    // released bus must not keep showing the last byte
    wr_data_out <= ~d;
  endtask
endmodule

/* File: ats_taskfile_tb_top.sv */
// testbench for the task file drive/head, status and command block
`timescale 1ns/1ps
module ats_taskfile_tb_top;
  logic        sys_clk_in;
  logic        rst_b_in;
  logic        iord_b, iowr_b, alt_blk, oe_b, card_no, level_irq, irq_en;
  logic        ready, seek_done, fault, corrected_data_flag, phase, pdone, cdone, cerr;
  logic        start, linear, sel, aborted, irq_n;
  logic [1:0]  cfg_idx;
  logic [2:0]  addr;
  logic [3:0]  head;
  logic [6:0]  use_v;
  logic [7:0]  wdata, rdata, feat, count, sector, cyl_lo, cyl_hi, code, feat_o;
  logic [8:0]  xcount, q;
  logic [27:0] linear_addressing_flag;
  logic [7:0]  codes [5] = '{8'h90, 8'hEC, 8'hEF, 8'hCD, 8'h38};
  logic [6:0]  uses [5] = '{7'h10, 7'h10, 7'h11, 7'h7E, 7'h7E};
  int          bad_count, num_checks, starts, aborts;

  ats_taskfile u_ats_taskfile
  (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .iord_b_in(iord_b), .iowr_b_in(iowr_b),
    .alt_block_in(alt_blk), .addr_in(addr), .data_in(wdata), .data_out(rdata),
    .data_oe_b_out(oe_b), .card_number_in(card_no), .config_index_in(cfg_idx),
    .level_irq_in(level_irq), .irq_enable_in(irq_en), .feature_in(feat), .count_in(count),
    .sector_in(sector), .cyl_low_in(cyl_lo), .cyl_high_in(cyl_hi), .ready_in(ready),
    .seek_done_in(seek_done), .write_fault_in(fault), .corrected_in(corrected_data_flag),
    .data_phase_in(phase), .data_done_in(pdone), .cmd_done_in(cdone), .cmd_error_in(cerr),
    .cmd_start_out(start), .cmd_code_out(code), .cmd_use_out(use_v), .feature_out(feat_o),
    .xfer_count_out(xcount), .lba_addr_out(linear_addressing_flag), .linear_addressing_flag_out(linear),
    .card_select_bit_out(sel), .head_field_out(head), .aborted_flag_out(aborted),
    .interrupt_request_n_out(irq_n)
  );
  ats_host_model u_ats_host_model
  (
    .sys_clk_in(sys_clk_in), .rd_data_in(rdata), .rd_oe_b_in(oe_b), .iord_b_out(iord_b),
    .iowr_b_out(iowr_b), .alt_block_out(alt_blk), .addr_out(addr), .wr_data_out(wdata)
  );

  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in)
  begin
    if (start === 1'b1) starts++;
    if (aborted === 1'b1) aborts++;
  end

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    num_checks++;
    if (got != exp)
    begin
      bad_count++;
      $display("unexpected at %0t: count %0d, wanted %0d", $time, got, exp);
    end
  endtask
  task automatic st(input logic alt, input logic [7:0] exp, input logic [7:0] m);
    u_ats_host_model.acc(1'b0, alt, alt ? ats_pkg::OFS_STATUS_ALT : ats_pkg::OFS_STATUS,
                         8'h00, q);
    chk({q[8], q[7:0] & m}, {1'b0, exp & m});
  endtask
  task automatic dh(input logic [7:0] d, input logic [7:0] exp);
    u_ats_host_model.acc(1'b1, 1'b0, ats_pkg::OFS_DRIVE_HEAD, d, q);
    u_ats_host_model.acc(1'b0, 1'b0, ats_pkg::OFS_DRIVE_HEAD, 8'h00, q);
    chk(q, {1'b0, exp});
  endtask
  task automatic cmd(input logic [7:0] c, input int s, input int a);
    int s0;
    int a0;
    s0 = starts;
    a0 = aborts;
    u_ats_host_model.acc(1'b1, 1'b0, ats_pkg::OFS_COMMAND, c, q);
    chk_n(starts - s0, s);
    chk_n(aborts - a0, a);
  endtask
  // one-cycle back end pulses: corrected, data phase, data done, command done
  task automatic pulse(input logic [3:0] p);
    {corrected_data_flag, phase, pdone, cdone} <= p;
    @(posedge sys_clk_in);
    {corrected_data_flag, phase, pdone, cdone} <= 4'h0;
    repeat (3) @(posedge sys_clk_in);
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk_in);
    bad_count++;
    finish_test();
  end
  initial
  begin
    rst_b_in = 1'b0;
    cfg_idx = 2'h1;
    {ready, seek_done, level_irq, irq_en} = 4'hF;
    {card_no, fault, corrected_data_flag, phase, pdone, cdone, cerr} = 7'h00;
    {feat, count, sector, cyl_lo, cyl_hi} = 40'h0;
    repeat (8) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    @(posedge sys_clk_in);
    u_ats_host_model.acc(1'b0, 1'b0, ats_pkg::OFS_DRIVE_HEAD, 8'h00, q);
    chk(q, {1'b0, ats_pkg::DH_RESET});
    st(1'b0, 8'h50, 8'hFF);
    dh(8'h5F, 8'hFF);
    chk({linear, sel, head}, 6'h3F);
    dh(8'h03, 8'hA3);
    chk({linear, sel, head}, 6'h03);
    {feat, sector, cyl_lo, cyl_hi} <= 32'h3C112233;
    dh(8'h4A, 8'hEA);
    for (int i = 0; i < 5; i++)
    begin
      count <= (i >= 3) ? 8'h05 : 8'h00;
      cerr <= (i == 1);
      cmd(codes[i], 1, 0);
      chk(code, codes[i]);
      chk(use_v, uses[i]);
      chk(feat_o, (i == 2) ? 8'h3C : 8'h00);
      chk(xcount, (i >= 3) ? 9'h005 : 9'h100);
      chk(linear_addressing_flag, 28'hA332211);
      st(1'b0, 8'h80, 8'h80);
      if (i == 3)
      begin
        pulse(4'h4);
        st(1'b1, 8'h58, 8'hFF);
        chk(irq_n, 1'b0);
        st(1'b0, 8'h58, 8'hFF);
        chk(irq_n, 1'b1);
      end
      else
      begin
        pulse(4'h1);
        chk(irq_n, 1'b0);
        st(1'b0, (i == 1) ? 8'h51 : 8'h50, 8'hFF);
      end
    end
    pulse(4'h8);
    st(1'b0, 8'h54, 8'hFF);
    ready <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      cfg_idx <= (i == 4) ? 2'h1 : i[1:0];
      level_irq <= (i != 4);
      cmd(8'h20, 0, 1);
      chk(irq_n, 1'b0);
      st(1'b1, 8'h11, 8'hFB);
      chk(irq_n, 1'b0);
      st(1'b0, 8'h11, 8'hFB);
      chk(irq_n, i != 0 && i != 4);
    end
    {ready, fault} <= 2'h3;
    cmd(8'hEC, 0, 1);
    st(1'b0, 8'h71, 8'hFB);
    {fault, seek_done} <= 2'h0;
    cmd(8'h20, 0, 1);
    st(1'b0, 8'h41, 8'hFB);
    cmd(8'hEC, 1, 0);
    pulse(4'h1);
    st(1'b0, 8'h40, 8'hFB);
    {seek_done, card_no} <= 2'h3;
    cmd(8'h90, 0, 0);
    dh(8'h10, 8'hB0);
    cmd(8'h90, 1, 0);
    pulse(4'h4);
    pulse(4'h2);
    st(1'b0, 8'h80, 8'h88);
    pulse(4'h1);
    u_ats_host_model.acc(1'b0, 1'b0, 3'h3, 8'h00, q);
    chk(q[8], 1'b1);
    {ready, irq_en} <= 2'h0;
    cmd(8'h20, 0, 1);
    chk(irq_n, 1'b1);
    finish_test();
  end
endmodule
